// ===== test/field_model.sv
`timescale 1ns/1ps
// field side of the pins: pulled-up input pads and fan tach sensors
module field_model #(
  parameter int DI_W = 3
) (
  // control from the bench
  input  wire logic            clk_i,
  input  wire logic [DI_W-1:0] gnd_i,
  input  wire logic [2:0]      run_i,
  // pins
  output logic      [DI_W-1:0] din_o,
  output logic      [2:0]      tach_o
);
  logic [3:0] div_q  = 4'h0;
  logic [2:0] tach_q = 3'h0;
  assign din_o = ~gnd_i;
  // one rising edge per 8 clocks, so a window count is exact
  always @(posedge clk_i) begin
    div_q <= div_q + 4'h1;
    tach_q <= run_i & {3{div_q[2]}};
  end
  assign tach_o = tach_q;
endmodule

// ===== test/host_watchdog_tb_top.sv
`timescale 1ns/1ps
module host_watchdog_tb_top;
  import wdog_pkg::*;
  localparam int MSC = 8;
  logic        clk, rst_n, psel, pen, pwr, jmp, pready, pslverr, hrst, cks, irq, err;
  logic [7:0]  paddr, naddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  din, tach, dout, pwm, gnd, s, p;
  logic [3:0]  baud;
  logic [7:0]  d0, d1;
  logic [4:0]  a;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, n_hrst = 0, c0, c1, c2;

  host_watchdog #(.MS_CYCLES(MSC), .FAN_WIN(4), .HOST_RST_LEN(2)) DUT (
    .CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CFG_INIT_JUMPER_I(jmp), .DIN_I(din), .FAN_TACH_I(tach),
    .DOUT_O(dout), .PWM_O(pwm), .HOST_RST_O(hrst), .NODE_ADDR_O(naddr),
    .BAUD_SEL_O(baud), .CKSUM_EN_O(cks), .IRQ_O(irq));
  field_model #(.DI_W(3)) FIELD (.clk_i(clk), .gnd_i(gnd), .run_i(3'b001),
    .din_o(din), .tach_o(tach));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // cycle count and host reset cycles; the sequence looks at growth only
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hrst === 1'b1) n_hrst <= n_hrst + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; holds everything until pready is seen high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge clk);
    pen <= 1'b1;
    // no wait limit of our own; a hang runs into the bench timeout
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt);
    // the write lands at the access edge; pins are looked at one edge later
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(r, exp);
  endtask
  function automatic logic [31:0] clampf(input logic [31:0] v);
    return (v < 32'(TOUT_MIN)) ? 32'(TOUT_MIN) : (v > 32'(TOUT_MAX)) ? 32'(TOUT_MAX) : v;
  endfunction
  function automatic logic [31:0] cfg();
    return {19'h0, naddr, baud, cks};
  endfunction
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    {psel, pen, pwr, jmp} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    gnd = 3'h0;
    void'($urandom(32'h1c090ddc));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(cfg(), {19'h0, NODE_ADDR_RST, BAUD_9600, 1'b0});
    chk({29'h0, dout}, {29'h0, NV_ERASED[2:0]});
    // pads, outputs, unmapped place
    gnd <= 3'($urandom);
    repeat (4) @(posedge clk);
    rd(A_DIN, {29'h0, ~gnd});
    repeat (3) begin
      s = 3'($urandom);
      wr(A_DOUT, {29'h0, s});
      rd(A_DOUT, {29'h0, s});
    end
    rd(8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test pins done");
    // pattern capture; power-on pattern seen after a reset
    p = 3'($urandom);
    wr(A_DOUT, {29'h0, p});
    wr(A_CTRL, 32'h1 << C_SAVE_PON);
    s = ~p;
    wr(A_DOUT, {29'h0, s});
    wr(A_CTRL, 32'h1 << C_SAVE_SAFE);
    rd(A_SAFE, {29'h0, s});
    rd(A_PWRON, {29'h0, p});
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({29'h0, dout}, {29'h0, p});
    $display("test patterns done");
    // timeout limits
    wr(A_TOUT, 32'h0);
    rd(A_TOUT, clampf(32'h0));
    wr(A_TOUT, 32'h3ffff);
    rd(A_TOUT, clampf(32'h3ffff));
    wr(A_TOUT, 32'h3);
    wr(A_MASK, 32'h1);
    // alive keeps the host alive, silence resets it
    wr(A_CTRL, 32'h1 << C_EN);
    c1 = n_hrst;
    repeat (8) wr(A_CTRL, 32'h1 << C_ALIVE);
    chk(32'(n_hrst - c1), 32'h0);
    c0 = 0;
    while (hrst !== 1'b1 && c0 < 100) begin
      @(posedge clk);
      c0++;
    end
    chk({31'h0, hrst}, 32'h1);
    chk({29'h0, dout}, {29'h0, s});
    rd(A_CTRL, {29'h0, 1'b1, 1'b1, 1'b0});
    chk({31'h0, irq}, 32'h1);
    wr(A_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(A_MASK, 32'h1);
    wr(A_DOUT, {29'h0, p});
    chk({29'h0, dout}, {29'h0, s});
    wr(A_CTRL, 32'h1 << C_CLR);
    wr(A_DOUT, {29'h0, p});
    chk({29'h0, dout}, {29'h0, p});
    wr(A_STS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // a disabled watchdog stays quiet
    wr(A_CTRL, 32'h1 << C_EN);
    wr(A_CTRL, 32'h1 << C_DIS);
    c1 = n_hrst;
    repeat (60) @(posedge clk);
    chk(32'(n_hrst - c1), 32'h0);
    $display("test watchdog done");
    repeat (4) begin
      a = 5'($urandom);
      d0 = 8'($urandom);
      wr(A_EE, {15'h0, 1'b1, 3'h0, a, d0});
      rd(A_EE, {19'h0, a, d0});
    end
    // baud and checksum only with the jumper in; node address is written either way
    wr(A_COMM, 32'h1522);
    chk(cfg(), {19'h0, 8'h22, BAUD_9600, 1'b0});
    jmp <= 1'b1;
    wr(A_COMM, 32'h1522);
    chk(cfg(), {19'h0, 8'h22, 4'h5, 1'b1});
    jmp <= 1'b0;
    wr(A_CTRL, 32'h1 << C_CFG_RST);
    chk(cfg(), {19'h0, NODE_ADDR_RST, BAUD_9600, 1'b0});
    rd(A_COMM, {19'h0, 1'b0, BAUD_9600, NODE_ADDR_RST});
    // duty over one full pwm period, extremes on two channels
    d0 = 8'($urandom);
    d1 = 8'hff;
    wr(A_PWM, {16'h0, d1, d0});
    {c0, c1, c2} = 0;
    repeat (256) begin
      @(posedge clk);
      c0 += pwm[0];
      c1 += pwm[1];
      c2 += pwm[2];
    end
    chk(c0, {24'h0, d0});
    chk(c1, {24'h0, d1});
    chk(c2, 32'h0);
    rd(A_FAN0, 32'h4);
    rd(A_FAN2, 32'h0);
    $display("test link and fans done");
    summarize();
  end
endmodule

// ===== verilog/host_watchdog.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module host_watchdog
  import wdog_pkg::*;
#(
  parameter int MS_CYCLES    = MS_CYC,
  parameter int DO_W         = 3,
  parameter int DI_W         = 3,
  parameter int FAN_WIN      = FAN_WIN_MS,
  parameter int HOST_RST_LEN = HOST_RST_MS
) (
  // clock and reset
  input  wire logic            CLOCK_I,
  input  wire logic            RST_N_I,
  // apb slave
  input  wire logic            PSEL_I,
  input  wire logic            PENABLE_I,
  input  wire logic            PWRITE_I,
  input  wire logic [7:0]      PADDR_I,
  input  wire logic [31:0]     PWDATA_I,
  output logic      [31:0]     PRDATA_O,
  output logic                 PREADY_O,
  output logic                 PSLVERR_O,
  // pins
  input  wire logic            CFG_INIT_JUMPER_I,
  input  wire logic [DI_W-1:0] DIN_I,
  input  wire logic [2:0]      FAN_TACH_I,
  output logic      [DO_W-1:0] DOUT_O,
  output logic      [2:0]      PWM_O,
  output logic                 HOST_RST_O,
  output logic      [7:0]      NODE_ADDR_O,
  output logic      [3:0]      BAUD_SEL_O,
  output logic                 CKSUM_EN_O,
  output logic                 IRQ_O
);

  // refuse sizes the counters cannot hold
  if (DO_W < 1 || DO_W > 8 || DI_W < 1 || DI_W > 32 || MS_CYCLES < 2 ||
      MS_CYCLES > 65536 || FAN_WIN < 1 || FAN_WIN > 1024 ||
      HOST_RST_LEN < 1 || HOST_RST_LEN > 255) begin : g_bad
    $error("host_watchdog: parameter out of range");
  end

  // all block state except the nonvolatile bytes in one packed record
  typedef struct packed {
    logic        wd_en;
    logic [17:0] wd_cnt;
    logic [17:0] tout;
    logic [15:0] ms_cnt;
    logic        fail;
    logic [7:0]  hrst_cnt;
    logic [7:0]  dout;
    logic [7:0]  addr;
    logic [3:0]  baud;
    logic        cksum;
    logic [2:0]  tach_prev;
    logic [47:0] tach_cnt;
    logic [47:0] fan_spd;
    logic [9:0]  win_cnt;
    logic [7:0]  pwm_cnt;
    logic [23:0] duty;
    logic [1:0]  sts;
    logic [1:0]  mask;
    logic [4:0]  ee_addr;
    logic [31:0] prdata;
    logic        slverr;
  } state_t;

  state_t     s_q;
  state_t     s_d;
  // bytes 0..31 user, then power-on and safe patterns; no reset, survives it
  logic [7:0] nv_q [0:NV_SAFE] = '{default: NV_ERASED};

  // bus decode and timing strobes
  logic       wr;
  logic       ms_tick;
  logic       c_wr;
  logic       expire;
  logic [1:0] sts_set;

  // checks below share this clock and reset
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  function automatic logic [17:0] clamp_tout(input logic [31:0] v);
    if (v < 32'(TOUT_MIN)) return TOUT_MIN;
    if (v > 32'(TOUT_MAX)) return TOUT_MAX;
    return v[17:0];
  endfunction

  // bus qualifiers; writes act only at the access edge
  assign wr      = PSEL_I & PENABLE_I & PWRITE_I;
  assign c_wr    = wr && PADDR_I == A_CTRL;
  assign ms_tick = s_q.ms_cnt == 16'(MS_CYCLES - 1);
  // an alive or disable in the last millisecond beats the expiry
  assign expire  = s_q.wd_en && ms_tick && s_q.wd_cnt <= 18'd1 &&
                   !(c_wr && (PWDATA_I[C_ALIVE] || PWDATA_I[C_DIS]));

  // next state
  always_comb begin
    s_d     = s_q;
    sts_set = 2'b00;
    // free-running millisecond prescaler, never held off
    s_d.ms_cnt  = ms_tick ? 16'h0000 : s_q.ms_cnt + 16'h0001;
    s_d.pwm_cnt = s_q.pwm_cnt + 8'h01;
    s_d.tach_prev = FAN_TACH_I;
    for (int i = 0; i < 3; i++) begin
      if (FAN_TACH_I[i] && !s_q.tach_prev[i]) begin
        s_d.tach_cnt[i*16 +: 16] = s_q.tach_cnt[i*16 +: 16] + 16'h0001;
      end
    end
    // window close, host reset pulse and countdown move on ms ticks only
    if (ms_tick) begin
      if (s_q.win_cnt == 10'(FAN_WIN - 1)) begin
        s_d.win_cnt  = 10'h000;
        s_d.fan_spd  = s_d.tach_cnt;
        s_d.tach_cnt = 48'h0;
        sts_set[ST_FAN] = 1'b1;
      end else begin
        s_d.win_cnt = s_q.win_cnt + 10'h001;
      end
      if (s_q.hrst_cnt != 8'h00) begin
        s_d.hrst_cnt = s_q.hrst_cnt - 8'h01;
      end
      if (s_q.wd_en && !expire) begin
        s_d.wd_cnt = s_q.wd_cnt - 18'd1;
      end
    end
    // control commands
    if (c_wr) begin
      // enable while already running restarts the full count
      if (PWDATA_I[C_EN]) begin
        s_d.wd_en  = 1'b1;
        s_d.wd_cnt = s_q.tout;
      end
      if (PWDATA_I[C_DIS]) begin
        s_d.wd_en = 1'b0;
      end
      if (PWDATA_I[C_ALIVE] && s_q.wd_en && !PWDATA_I[C_DIS]) begin
        s_d.wd_cnt = s_q.tout;
      end
      // fail clear; an expiry in the same cycle still wins below
      if (PWDATA_I[C_CLR]) begin
        s_d.fail = 1'b0;
      end
      if (PWDATA_I[C_CFG_RST]) begin
        s_d.addr  = NODE_ADDR_RST;
        s_d.baud  = BAUD_9600;
        s_d.cksum = 1'b0;
      end
    end
    if (wr) begin
      case (PADDR_I)
        A_TOUT: s_d.tout = clamp_tout(PWDATA_I);
        A_DOUT: if (!s_q.fail) s_d.dout = PWDATA_I[7:0];
        A_COMM: begin
          s_d.addr = PWDATA_I[7:0];
          if (CFG_INIT_JUMPER_I) begin
            s_d.baud  = PWDATA_I[COMM_BAUD_LSB +: 4];
            s_d.cksum = PWDATA_I[COMM_CKSUM];
          end
        end
        // address latched even without the strobe, for later reads
        A_EE:   s_d.ee_addr = PWDATA_I[EE_ADDR_LSB +: 5];
        A_PWM:  s_d.duty = PWDATA_I[23:0];
        A_MASK: s_d.mask = PWDATA_I[1:0];
        default: ;
      endcase
    end
    // expiry: reset host, force safe pattern; set beats clear
    if (expire) begin
      s_d.fail     = 1'b1;
      s_d.wd_en    = 1'b0;
      s_d.hrst_cnt = 8'(HOST_RST_LEN);
      s_d.dout     = nv_q[NV_SAFE];
      sts_set[ST_WDF] = 1'b1;
    end
    // sticky status, write one to clear, a new event wins
    s_d.sts = s_q.sts | sts_set;
    if (wr && PADDR_I == A_STS) begin
      s_d.sts = (s_q.sts & ~PWDATA_I[1:0]) | sts_set;
    end
    // read data captured in the setup cycle, so access needs no wait
    if (PSEL_I && !PENABLE_I) begin
      s_d.slverr = 1'b0;
      case (PADDR_I)
        A_CTRL:  s_d.prdata = {29'h0, s_q.fail, s_q.hrst_cnt != 8'h00, s_q.wd_en};
        A_TOUT:  s_d.prdata = {14'h0, s_q.tout};
        A_DOUT:  s_d.prdata = {24'h0, s_q.dout};
        // pads carry pull-ups, so an open input reads one
        A_DIN:   s_d.prdata = 32'(DIN_I);
        A_COMM:  s_d.prdata = {19'h0, s_q.cksum, s_q.baud, s_q.addr};
        A_PWRON: s_d.prdata = {24'h0, nv_q[NV_PWRON]};
        A_SAFE:  s_d.prdata = {24'h0, nv_q[NV_SAFE]};
        A_EE:    s_d.prdata = {19'h0, s_q.ee_addr, nv_q[s_q.ee_addr]};
        A_FAN0:  s_d.prdata = {16'h0, s_q.fan_spd[15:0]};
        A_FAN1:  s_d.prdata = {16'h0, s_q.fan_spd[31:16]};
        A_FAN2:  s_d.prdata = {16'h0, s_q.fan_spd[47:32]};
        A_PWM:   s_d.prdata = {8'h0, s_q.duty};
        A_STS:   s_d.prdata = {30'h0, s_q.sts};
        A_MASK:  s_d.prdata = {30'h0, s_q.mask};
        default: begin
          s_d.prdata = 32'h0;
          s_d.slverr = 1'b1;
        end
      endcase
    end
    // reset: defaults, outputs from stored power-on pattern
    if (!RST_N_I) begin
      s_d       = '0;
      s_d.tout  = TOUT_MIN;
      s_d.addr  = NODE_ADDR_RST;
      s_d.baud  = BAUD_9600;
      s_d.dout  = nv_q[NV_PWRON];
    end
  end

  // one register for all state but nv_q; reset is folded into the next-state logic
  always_ff @(posedge CLOCK_I) begin
    s_q <= s_d;
  end

  // nonvolatile writes; the captured pattern is the one driving the pins
  // a save in the expiry cycle stores the pattern from before the safe load
  always_ff @(posedge CLOCK_I) begin
    if (RST_N_I && c_wr) begin
      if (PWDATA_I[C_SAVE_PON]) begin
        nv_q[NV_PWRON] <= s_q.dout;
      end
      if (PWDATA_I[C_SAVE_SAFE]) begin
        nv_q[NV_SAFE] <= s_q.dout;
      end
    end
    if (RST_N_I && wr && PADDR_I == A_EE && PWDATA_I[EE_WR]) begin
      nv_q[PWDATA_I[EE_ADDR_LSB +: 5]] <= PWDATA_I[7:0];
    end
  end

  // outputs
  assign PRDATA_O    = s_q.prdata;
  assign PSLVERR_O   = s_q.slverr & PSEL_I & PENABLE_I;
  assign PREADY_O    = 1'b1;
  assign DOUT_O      = s_q.dout[DO_W-1:0];
  assign HOST_RST_O  = s_q.hrst_cnt != 8'h00;
  assign NODE_ADDR_O = s_q.addr;
  assign BAUD_SEL_O  = s_q.baud;
  assign CKSUM_EN_O  = s_q.cksum;
  assign IRQ_O       = |(s_q.sts & s_q.mask);
  // compare per channel; a duty of zero keeps the fan off
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      PWM_O[i] = s_q.pwm_cnt < s_q.duty[i*8 +: 8];
    end
  end

  // checks
  chk_cfg_defaults: assert property (
    $rose(RST_N_I) |-> NODE_ADDR_O == NODE_ADDR_RST && BAUD_SEL_O == BAUD_9600 && !CKSUM_EN_O)
    else $error("config defaults wrong after reset");
  chk_expire_reset: assert property (
    expire |=> HOST_RST_O && s_q.fail && !s_q.wd_en)
    else $error("expiry did not reset host");
  chk_tout_range: assert property (
    wr && PADDR_I == A_TOUT |=> s_q.tout >= TOUT_MIN && s_q.tout <= TOUT_MAX)
    else $error("timeout outside range");
  chk_wd_disable: assert property (
    c_wr && PWDATA_I[C_DIS] && !expire |=> !s_q.wd_en ##1 !HOST_RST_O || $past(HOST_RST_O))
    else $error("disable did not stop watchdog");
  chk_safe_out: assert property (
    $rose(s_q.fail) |-> DOUT_O == nv_q[NV_SAFE][DO_W-1:0])
    else $error("safe pattern not applied");
  chk_power_on: assert property (
    $rose(RST_N_I) |-> DOUT_O == nv_q[NV_PWRON][DO_W-1:0])
    else $error("power-on pattern not applied");
  chk_capture_safe: assert property (
    c_wr && PWDATA_I[C_SAVE_SAFE] |=> nv_q[NV_SAFE] == $past(s_q.dout))
    else $error("safe pattern not captured");
  chk_din_read: assert property (
    PSEL_I && !PENABLE_I && PADDR_I == A_DIN |=> PRDATA_O == 32'($past(DIN_I)))
    else $error("input read mismatch");
  chk_ee_write: assert property (
    wr && PADDR_I == A_EE && PWDATA_I[EE_WR] |=>
      nv_q[$past(PWDATA_I[EE_ADDR_LSB +: 5])] == $past(PWDATA_I[7:0]))
    else $error("user byte not stored");
  chk_baud_lock: assert property (
    wr && PADDR_I == A_COMM && !CFG_INIT_JUMPER_I && !c_wr |=> $stable(BAUD_SEL_O) && $stable(CKSUM_EN_O))
    else $error("baud changed without jumper");
  chk_dout_write: assert property (
    wr && PADDR_I == A_DOUT && !s_q.fail && !expire |=> DOUT_O == $past(PWDATA_I[DO_W-1:0]))
    else $error("output write lost");
  chk_dout_reject: assert property (
    s_q.fail && wr && PADDR_I == A_DOUT |=> $stable(DOUT_O))
    else $error("output write accepted during failure");
  chk_alive_reload: assert property (
    c_wr && PWDATA_I[C_ALIVE] && s_q.wd_en && !PWDATA_I[C_DIS] |=> s_q.wd_cnt == s_q.tout)
    else $error("alive did not reload timeout");
  // pwm, fan window, status and host reset pulse
  chk_duty_update: assert property (
    wr && PADDR_I == A_PWM |=> s_q.duty == $past(PWDATA_I[23:0]))
    else $error("duty not applied");
  chk_fan_window: assert property (
    sts_set[ST_FAN] |=> s_q.tach_cnt == 48'h0)
    else $error("fan window did not restart");
  chk_sts_sticky: assert property (
    s_q.sts[ST_WDF] && !(wr && PADDR_I == A_STS && PWDATA_I[ST_WDF]) |=> s_q.sts[ST_WDF])
    else $error("expiry status lost");
  chk_hrst_hold: assert property (
    $rose(HOST_RST_O) |=> HOST_RST_O)
    else $error("host reset pulse too short");
  // main scenarios for coverage
  cov_expire: cover property (expire);
  cov_clear: cover property (s_q.fail ##1 !s_q.fail);
  cov_fan: cover property (sts_set[ST_FAN]);
  cov_reject: cover property (s_q.fail && wr && PADDR_I == A_DOUT);
  cov_reload: cover property (c_wr && PWDATA_I[C_ALIVE] && s_q.wd_en);

endmodule

// ===== verilog/wdog_pkg.sv
package wdog_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_TOUT  = 8'h04;
  localparam logic [7:0] A_DOUT  = 8'h08;
  localparam logic [7:0] A_DIN   = 8'h0c;
  localparam logic [7:0] A_COMM  = 8'h10;
  localparam logic [7:0] A_PWRON = 8'h14;
  localparam logic [7:0] A_SAFE  = 8'h18;
  localparam logic [7:0] A_EE    = 8'h1c;
  localparam logic [7:0] A_FAN0  = 8'h20;
  localparam logic [7:0] A_FAN1  = 8'h24;
  localparam logic [7:0] A_FAN2  = 8'h28;
  localparam logic [7:0] A_PWM   = 8'h2c;
  localparam logic [7:0] A_STS   = 8'h30;
  localparam logic [7:0] A_MASK  = 8'h34;
  // control bits, all write-one actions
  localparam int C_EN        = 0;
  localparam int C_DIS       = 1;
  localparam int C_ALIVE     = 2;
  localparam int C_CLR       = 3;
  localparam int C_SAVE_PON  = 4;
  localparam int C_SAVE_SAFE = 5;
  localparam int C_CFG_RST   = 6;
  // comm and eeprom field positions
  localparam int COMM_BAUD_LSB = 8;
  localparam int COMM_CKSUM    = 12;
  localparam int EE_ADDR_LSB   = 8;
  localparam int EE_WR         = 16;
  // status bits
  localparam int ST_WDF = 0;
  localparam int ST_FAN = 1;
  // reset values and the timeout ceiling
  localparam logic [7:0]  NODE_ADDR_RST = 8'h01;
  localparam logic [3:0]  BAUD_9600     = 4'h3;
  localparam logic [17:0] TOUT_MIN      = 18'd3;
  localparam logic [17:0] TOUT_MAX      = 18'd196605;
  localparam logic [7:0]  NV_ERASED     = 8'hff;
  // nonvolatile layout
  localparam int NV_BYTES = 32;
  localparam int NV_PWRON = 32;
  localparam int NV_SAFE  = 33;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
  localparam int HOST_RST_MS   = 100;
  localparam int FAN_WIN_MS    = 1000;
endpackage
